// >>> rtl/msc_pkg.sv
package msc_pkg;

   // ==========================================================
   // register bus geometry
   localparam int                ADDR_W             = 8;
   localparam int                DATA_W             = 16;

   // ==========================================================
   // register offsets
   localparam logic [7:0]        OFS_MODE_REPORT    = 8'h00;
   localparam logic [7:0]        OFS_SYSTEM_CONTROL = 8'h02;

   // ==========================================================
   // operating mode report layout
   localparam int                MODE_FIELD_LSB     = 8;
   localparam int                MODE_FIELD_W       = 4;
   localparam int                MODE_LOW_LSB       = 0;
   localparam logic [3:0]        MODE_FIXED_PATTERN = 4'h5;
   localparam int                MODE_FIXED_HI_LSB  = 12;
   localparam int                MODE_FIXED_LO_LSB  = 4;
   localparam logic [3:0]        MODE1_CODE         = 4'hD;
   localparam logic [3:0]        MODE2_CODE         = 4'hC;
   localparam logic [3:0]        MODE3_CODE         = 4'h4;
   localparam logic [3:0]        MODE_NONE_CODE     = 4'h0;

   // mode pin patterns {mode_pin_high, mode_pin_low}
   localparam logic [1:0]        PINS_MODE1         = 2'h1;
   localparam logic [1:0]        PINS_MODE2         = 2'h2;
   localparam logic [1:0]        PINS_MODE3         = 2'h3;

   // mode numbers reported on the mode output, zero for none
   localparam logic [1:0]        MODE_NUM_NONE      = 2'h0;
   localparam logic [1:0]        MODE_NUM_1         = 2'h1;
   localparam logic [1:0]        MODE_NUM_2         = 2'h2;
   localparam logic [1:0]        MODE_NUM_3         = 2'h3;

   // ==========================================================
   // system control layout
   localparam int                SC_MAC_SAT_BIT     = 13;
   localparam int                SC_RAM_EN_BIT      = 8;
   localparam int                SC_FLASH_EN_BIT    = 7;
   localparam int                SC_XFER_MODE_BIT   = 1;
   localparam logic [15:0]       SC_READ_ONES       = 16'hD401;
   localparam logic              SC_MAC_SAT_RESET   = 1'b0;
   localparam logic              SC_RAM_EN_RESET    = 1'b1;
   localparam logic              SC_FLASH_EN_RESET  = 1'b0;
   localparam logic              SC_XFER_MODE_RESET = 1'b1;

   // ==========================================================
   // processing states
   typedef enum logic [2:0] {
      PS_RESET,
      PS_EXCEPTION,
      PS_EXECUTE,
      PS_BUS_RELEASED,
      PS_STOPPED
   } msc_proc_state_type;

   // requests that steer the processing state
   typedef struct packed {
      logic exceptionReq;
      logic busRequest;
      logic sleepReq;
      logic standbyReq;
      logic wakeReq;
      logic vectorDone;
   } msc_proc_req_type;

   // processing state indications
   typedef struct packed {
      msc_proc_state_type state;
      logic               intMasked;
      logic               vectorFetch;
      logic               busGrant;
      logic               cpuHalted;
      logic               cpuStopped;
   } msc_proc_out_type;

endpackage

// >>> rtl/msc_proc_seq.sv
module msc_proc_seq
   import msc_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             sysReset,
   input  wire msc_proc_req_type req,
   output msc_proc_out_type      status
);

   // ==========================================================
   // state transitions
   msc_proc_state_type stateNext;
   msc_proc_state_type state_reg;

   // exception beats bus release, which beats sleep
   always_comb begin
      stateNext = state_reg;
      unique case (state_reg)
         PS_RESET: begin
            stateNext = PS_EXCEPTION;
         end
         PS_EXCEPTION: begin
            if (req.vectorDone) begin
               stateNext = PS_EXECUTE;
            end
         end
         PS_EXECUTE: begin
            if (req.exceptionReq) begin
               stateNext = PS_EXCEPTION;
            end else if (req.busRequest) begin
               stateNext = PS_BUS_RELEASED;
            end else if (req.sleepReq || req.standbyReq) begin
               stateNext = PS_STOPPED;
            end
         end
         PS_BUS_RELEASED: begin
            if (!req.busRequest) begin
               stateNext = PS_EXECUTE;
            end
         end
         PS_STOPPED: begin
            if (req.wakeReq) begin
               stateNext = PS_EXCEPTION;
            end
         end
      endcase
   end

   // ==========================================================
   // outputs registered from the next state so they track state_reg
   always_ff @(posedge clk_sys) begin
      if (sysReset) begin
         state_reg          <= PS_RESET;
         status.state       <= PS_RESET;
         status.intMasked   <= 1'b1;
         status.vectorFetch <= 1'b0;
         status.busGrant    <= 1'b0;
         status.cpuHalted   <= 1'b1;
         status.cpuStopped  <= 1'b0;
      end else begin
         state_reg          <= stateNext;
         status.state       <= stateNext;
         status.intMasked   <= (stateNext == PS_RESET) || (stateNext == PS_EXCEPTION);
         status.vectorFetch <= (stateNext == PS_EXCEPTION);
         status.busGrant    <= (stateNext == PS_BUS_RELEASED);
         status.cpuHalted   <= (stateNext != PS_EXECUTE) && (stateNext != PS_EXCEPTION);
         status.cpuStopped  <= (stateNext == PS_STOPPED);
      end
   end

endmodule

// >>> rtl/msc_mode_sysctrl.sv
// Operation
// - decode mode pins into modes one to three
// - reading mode register latches pins until reset
// - mode field reports 1101, 1100 or 0100
// - mode register read-only, fixed 0101 nibbles
// - bit 13 selects saturating multiply-accumulate
// - bit 8 enables RAM, set on reset
// - bit 7 gates flash control register access
// - bit 1 selects short transfer addressing
// - reserved system-control bits read fixed values
// - reset low stops, masks, restarts on release
// - watchdog overflow acts like the reset pin
// - exceptions fetch vector then branch
// - bus request releases bus, halts CPU
// - sleep or standby stops the CPU
// - flash programming only in modes one, two
// - mode three is advanced, 16 MB, ROM on
module msc_mode_sysctrl
   import msc_pkg::*;
(
   input  wire logic               clk_sys,
   input  wire logic               reset_n,

   // mode selection pins
   input  wire logic               mode_pin_high,
   input  wire logic               mode_pin_low,

   // watchdog overflow pulse
   input  wire logic               wdtOverflow,

   // register port
   input  wire logic [ADDR_W-1:0]  regAddr,
   input  wire logic [DATA_W-1:0]  regWdata,
   input  wire logic               regWrite,
   input  wire logic               regRead,
   output logic      [DATA_W-1:0]  regRdata,

   // flash control register access path
   input  wire logic               flashRegReq,
   output logic                    flashRegGrant,

   // processing state requests and indications
   input  wire msc_proc_req_type   procReq,
   output msc_proc_out_type        procStatus,

   // mode indications
   output logic      [1:0]         modeNumber,
   output logic                    modeValid,
   output logic                    flashProgAllowed,
   output logic                    advancedMode,
   output logic                    onchipRomEnable,

   // system control indications
   output logic                    mac_saturate_select,
   output logic                    onchip_ram_enable,
   output logic                    flash_ctrl_access_enable,
   output logic                    transfer_ctrl_addr_mode
);

   // ==========================================================
   // internal reset
   // watchdog overflow resets the same state as the pin
   // sampled on the clock edge, so a
   // one-cycle overflow pulse suffices
   // every register below shares it
   logic sysReset;

   assign sysReset = !reset_n || wdtOverflow;

   // ==========================================================
   // address decode
   // byte offsets, compared in full;
   // aliases read zero, take no writes
   logic hitMode;
   logic hitSysCtrl;

   assign hitMode    = (regAddr == OFS_MODE_REPORT);
   assign hitSysCtrl = (regAddr == OFS_SYSTEM_CONTROL);

   // ==========================================================
   // mode pin latch
   // pins are followed live until the first read of the mode
   // register; the read freezes them until the next reset
   // trade-off: unread, the mode
   // follows the pins, so straps must
   // settle before reset is released
   logic       pinsLatched_reg;
   logic [1:0] pinsLatch_reg;
   logic [1:0] livePins;
   logic [1:0] effPins;

   assign livePins = {mode_pin_high, mode_pin_low};
   assign effPins  = pinsLatched_reg ? pinsLatch_reg : livePins;

   // capture on the read strobe, release only by reset
   always_ff @(posedge clk_sys) begin
      if (sysReset) begin
         pinsLatched_reg <= 1'b0;
         pinsLatch_reg   <= 2'h0;
      end else if (regRead && hitMode && !pinsLatched_reg) begin
         pinsLatched_reg <= 1'b1;
         pinsLatch_reg   <= livePins;
      end
   end

   // ==========================================================
   // mode decode
   logic [3:0] modeCode;
   logic [1:0] modeNumNext;

   // the all-zero pattern is left without a mode
   // and raises no mode flag
   always_comb begin
      modeCode    = MODE_NONE_CODE;
      modeNumNext = MODE_NUM_NONE;
      unique case (effPins)
         PINS_MODE1: begin
            modeCode    = MODE1_CODE;
            modeNumNext = MODE_NUM_1;
         end

         PINS_MODE2: begin
            modeCode    = MODE2_CODE;
            modeNumNext = MODE_NUM_2;
         end

         PINS_MODE3: begin
            modeCode    = MODE3_CODE;
            modeNumNext = MODE_NUM_3;
         end

         default: begin
            modeCode    = MODE_NONE_CODE;
            modeNumNext = MODE_NUM_NONE;
         end
      endcase
   end

   // mode report word: fixed nibbles around the pin-derived code
   // low nibble repeats the code
   logic [DATA_W-1:0] modeWord;

   always_comb begin
      modeWord = '0;
      modeWord[MODE_FIXED_HI_LSB +: 4]         = MODE_FIXED_PATTERN;
      modeWord[MODE_FIELD_LSB +: MODE_FIELD_W] = modeCode;
      modeWord[MODE_FIXED_LO_LSB +: 4]         = MODE_FIXED_PATTERN;
      modeWord[MODE_LOW_LSB +: 4]              = modeCode;
   end

   // ==========================================================
   // mode indications
   // all supported modes share the advanced CPU mode with ROM on;
   // only the two boot modes may program or erase the flash
   // registered: they trail the pins
   // or the latch by one clock
   always_ff @(posedge clk_sys) begin
      if (sysReset) begin
         modeNumber       <= MODE_NUM_NONE;
         modeValid        <= 1'b0;
         flashProgAllowed <= 1'b0;
         advancedMode     <= 1'b0;
         onchipRomEnable  <= 1'b0;
      end else begin
         modeNumber       <= modeNumNext;
         modeValid        <= (modeNumNext != MODE_NUM_NONE);
         flashProgAllowed <= (modeNumNext == MODE_NUM_1) ||
                             (modeNumNext == MODE_NUM_2);
         advancedMode     <= (modeNumNext != MODE_NUM_NONE);
         onchipRomEnable  <= (modeNumNext != MODE_NUM_NONE);
      end
   end

   // ==========================================================
   // system control register
   // only four bits hold state; reserved bits are not stored,
   // so a stray write cannot disturb their read values
   // a write lands on the next edge;
   // the port never stalls
   logic macSat_reg;
   logic ramEn_reg;
   logic flashEn_reg;
   logic xferMode_reg;
   logic sysCtrlWrite;

   assign sysCtrlWrite = regWrite && hitSysCtrl;

   // multiply-accumulate saturation select
   always_ff @(posedge clk_sys) begin
      if (sysReset) begin
         macSat_reg <= SC_MAC_SAT_RESET;
      end else if (sysCtrlWrite) begin
         macSat_reg <= regWdata[SC_MAC_SAT_BIT];
      end
   end

   // on-chip ram enable, back to one whenever reset ends;
   // clearing it mid-access is left to software to avoid
   // hardware does not block it
   // ram is usable right after reset
   always_ff @(posedge clk_sys) begin
      if (sysReset) begin
         ramEn_reg <= SC_RAM_EN_RESET;
      end else if (sysCtrlWrite) begin
         ramEn_reg <= regWdata[SC_RAM_EN_BIT];
      end
   end

   // flash control register access enable
   // clearing it only gates the grant
   always_ff @(posedge clk_sys) begin
      if (sysReset) begin
         flashEn_reg <= SC_FLASH_EN_RESET;
      end else if (sysCtrlWrite) begin
         flashEn_reg <= regWdata[SC_FLASH_EN_BIT];
      end
   end

   // transfer controller address mode
   // one selects short addressing
   always_ff @(posedge clk_sys) begin
      if (sysReset) begin
         xferMode_reg <= SC_XFER_MODE_RESET;
      end else if (sysCtrlWrite) begin
         xferMode_reg <= regWdata[SC_XFER_MODE_BIT];
      end
   end

   // system control read image
   // reserved bits are constants
   logic [DATA_W-1:0] sysCtrlWord;

   always_comb begin
      sysCtrlWord                   = SC_READ_ONES;
      sysCtrlWord[SC_MAC_SAT_BIT]   = macSat_reg;
      sysCtrlWord[SC_RAM_EN_BIT]    = ramEn_reg;
      sysCtrlWord[SC_FLASH_EN_BIT]  = flashEn_reg;
      sysCtrlWord[SC_XFER_MODE_BIT] = xferMode_reg;
   end

   // ==========================================================
   // control outputs, one cycle after the register write
   // a flop per bit keeps outputs
   // clean at a cycle of latency
   // reset values match the stored bits
   always_ff @(posedge clk_sys) begin
      if (sysReset) begin
         mac_saturate_select      <= SC_MAC_SAT_RESET;
         onchip_ram_enable        <= SC_RAM_EN_RESET;
         flash_ctrl_access_enable <= SC_FLASH_EN_RESET;
         transfer_ctrl_addr_mode  <= SC_XFER_MODE_RESET;
      end else begin
         mac_saturate_select      <= macSat_reg;
         onchip_ram_enable        <= ramEn_reg;
         flash_ctrl_access_enable <= flashEn_reg;
         transfer_ctrl_addr_mode  <= xferMode_reg;
      end
   end

   // ==========================================================
   // flash control register gate
   // a blocked request is simply not granted, so the flash
   // control registers see no access and keep their contents
   // the grant trails the request
   // by one clock
   always_ff @(posedge clk_sys) begin
      if (sysReset) begin
         flashRegGrant <= 1'b0;
      end else begin
         flashRegGrant <= flashRegReq && flashEn_reg;
      end
   end

   // ==========================================================
   // read data
   // data stand one cycle after the strobe and only then;
   // the mode word uses the live pins in the capturing cycle,
   // which are exactly the value the latch takes
   // zero outside the answer cycle
   // lets several slaves be or-ed
   // unmapped offsets answer zero
   always_ff @(posedge clk_sys) begin
      if (sysReset) begin
         regRdata <= '0;
      end else if (regRead) begin
         if (hitMode) begin
            regRdata <= modeWord;
         end else if (hitSysCtrl) begin
            regRdata <= sysCtrlWord;
         end else begin
            regRdata <= '0;
         end
      end else begin
         regRdata <= '0;
      end
   end

   // ==========================================================
   // processing state sequencer
   // kept in its own module so the register bank stays flat
   // a watchdog overflow restarts it
   // through the reset state too
   msc_proc_seq u_proc_seq (
      .clk_sys  (clk_sys),
      .sysReset (sysReset),
      .req      (procReq),
      .status   (procStatus)
   );

   // ==========================================================
   // usage notes
   // the mode register is read-only
   // the first mode read freezes the
   // pins until the next reset
   // pin pattern 0/0 reports no mode

   // reserved control bits ignore
   // writes and read fixed values
   // software writes each reserved
   // bit with its read value
   // ram enable returns to one
   // whenever reset ends
   // unmapped offsets read zero

   // read data stand one cycle only
   // control outputs trail the
   // stored bits by one clock
   // the watchdog input acts as a
   // full synchronous reset
   // flash programming is allowed
   // only in modes one and two
   // the grant drops one clock after
   // the access enable is cleared

   // an exception beats bus release,
   // which beats sleep or standby
   // a wake passes through exception
   // entry before execution resumes
   // interrupts stay masked in the
   // reset and exception states
   // short transfer addressing and
   // plain multiply-accumulate are
   // the states after reset

endmodule

// >>> test/msc_mode_sysctrl_properties.sv
module msc_mode_sysctrl_properties
   import msc_pkg::*;
(
   input wire logic              clk_sys,
   input wire logic              reset_n,
   input wire logic              wdtOverflow,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   input wire logic              regWrite,
   input wire logic              regRead,
   input wire logic [DATA_W-1:0] regRdata,
   input wire logic              flashRegReq,
   input wire logic              flashRegGrant,
   input wire msc_proc_req_type  procReq,
   input wire msc_proc_out_type  procStatus,
   input wire logic [1:0]        modeNumber,
   input wire logic              modeValid,
   input wire logic              flashProgAllowed,
   input wire logic              advancedMode,
   input wire logic              onchipRomEnable,
   input wire logic              mac_saturate_select,
   input wire logic              onchip_ram_enable,
   input wire logic              flash_ctrl_access_enable,
   input wire logic              transfer_ctrl_addr_mode
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // helper terms: a watchdog overflow resets exactly like the pin
   logic       rst;
   logic [3:0] wrBits;
   logic [3:0] ctrlBits;
   assign rst = !reset_n || wdtOverflow;
   assign wrBits = {regWdata[13], regWdata[8], regWdata[7], regWdata[1]};
   assign ctrlBits = {mac_saturate_select, onchip_ram_enable, flash_ctrl_access_enable,
                      transfer_ctrl_addr_mode};
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   sequence s_release;
      rst ##1 !rst;
   endsequence
   sequence s_bus_taken;
      procStatus.state == PS_EXECUTE && procReq.busRequest && !procReq.exceptionReq;
   endsequence
   // ==========================================================
   // assertions
   a_reset_state: assert property (disable iff (1'h0) rst |=>
      procStatus.state == PS_RESET && procStatus.intMasked && ctrlBits == 4'h5)
      else $error("reset state not entered");
   a_release_exception: assert property (disable iff (1'h0) s_release |=>
      procStatus.state == PS_EXCEPTION && procStatus.vectorFetch)
      else $error("no exception handling after reset release");
   a_mode_word: assert property ($past(regRead) && $past(regAddr) == OFS_MODE_REPORT |->
      regRdata[15:12] == 4'h5 && regRdata[7:4] == 4'h5 && regRdata[11:8] == regRdata[3:0]
      && (regRdata[11:8] == 4'h0) == !modeValid)
      else $error("mode report word malformed");
   a_sys_fixed: assert property ($past(regRead) && $past(regAddr) == OFS_SYSTEM_CONTROL |->
      (regRdata & 16'hDE7D) == 16'hD401)
      else $error("system control fixed bits wrong");
   a_ctrl_write: assert property (regWrite && regAddr == OFS_SYSTEM_CONTROL |=>
      ##1 ctrlBits == $past(wrBits, 2))
      else $error("control outputs do not follow written bits");
   a_flash_grant: assert property (
      flashRegGrant == ($past(flashRegReq) && flash_ctrl_access_enable))
      else $error("flash register grant not gated by enable");
   a_mode_flags: assert property (modeValid == (modeNumber != 2'h0) &&
      advancedMode == modeValid && onchipRomEnable == modeValid &&
      flashProgAllowed == (modeNumber == 2'h1 || modeNumber == 2'h2))
      else $error("mode indications inconsistent");
   a_bus_release: assert property (s_bus_taken |=>
      procStatus.state == PS_BUS_RELEASED && procStatus.busGrant && procStatus.cpuHalted)
      else $error("bus not released on request");
   a_stop_entry: assert property (procStatus.state == PS_EXECUTE &&
      !procReq.exceptionReq && !procReq.busRequest && (procReq.sleepReq || procReq.standbyReq)
      |=> procStatus.state == PS_STOPPED && procStatus.cpuStopped)
      else $error("stop state not entered");
   a_exception_entry: assert property (
      procStatus.state == PS_EXECUTE && procReq.exceptionReq |=>
      procStatus.state == PS_EXCEPTION && procStatus.vectorFetch)
      else $error("exception not taken");
   a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 16'h0000)
      else $error("read data not idle outside the answer cycle");
endmodule

bind msc_mode_sysctrl msc_mode_sysctrl_properties u_props (
   .clk_sys, .reset_n, .wdtOverflow, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
   .flashRegReq, .flashRegGrant, .procReq, .procStatus, .modeNumber, .modeValid,
   .flashProgAllowed, .advancedMode, .onchipRomEnable, .mac_saturate_select,
   .onchip_ram_enable, .flash_ctrl_access_enable, .transfer_ctrl_addr_mode);

// >>> test/msc_board_model.sv
// ==========================================================
// board side: mode strapping and the reset pin
module msc_board_model (
   input  wire logic clk_sys,
   output logic      reset_n,
   output logic      mode_pin_high,
   output logic      mode_pin_low
);
   timeunit 1ns;
   timeprecision 100ps;
   // power-up: held in reset, strapped for single chip
   initial begin
      reset_n = 1'h0;
      mode_pin_high = 1'h1;
      mode_pin_low = 1'h1;
   end
   // straps are levels, changed just after an edge
   task automatic setPins(input logic [1:0] pins);
      @(posedge clk_sys);
      {mode_pin_high, mode_pin_low} <= pins;
   endtask
   task automatic pulseReset();
      @(posedge clk_sys);
      reset_n <= 1'h0;
      repeat (16) @(posedge clk_sys);
      reset_n <= 1'h1;
   endtask
endmodule

// >>> test/msc_mode_sysctrl_tb_top.sv
module msc_mode_sysctrl_tb_top import msc_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // signals
   logic              clk_sys = 1'h0;
   logic              wdtOverflow = 1'h0;
   logic              regWrite = 1'h0;
   logic              regRead = 1'h0;
   logic              flashRegReq = 1'h0;
   logic [ADDR_W-1:0] regAddr = 8'h00;
   logic [DATA_W-1:0] regWdata = 16'h0000;
   msc_proc_req_type  procReq = 6'h00;
   logic [DATA_W-1:0] regRdata;
   msc_proc_out_type  procStatus;
   logic [1:0]        modeNumber;
   logic              reset_n, mode_pin_high, mode_pin_low, flashRegGrant, modeValid;
   logic              flashProgAllowed, advancedMode, onchipRomEnable, mac_saturate_select;
   logic              onchip_ram_enable, flash_ctrl_access_enable, transfer_ctrl_addr_mode;
   int                errors = 0;
   int                compares = 0;
   int                cycles = 0;
   msc_board_model uBoard (.clk_sys, .reset_n, .mode_pin_high, .mode_pin_low);
   msc_mode_sysctrl uut (
      .clk_sys, .reset_n, .mode_pin_high, .mode_pin_low, .wdtOverflow, .regAddr, .regWdata,
      .regWrite, .regRead, .regRdata, .flashRegReq, .flashRegGrant, .procReq, .procStatus,
      .modeNumber, .modeValid, .flashProgAllowed, .advancedMode, .onchipRomEnable,
      .mac_saturate_select, .onchip_ram_enable, .flash_ctrl_access_enable,
      .transfer_ctrl_addr_mode);
   always #12.5 clk_sys = ~clk_sys;
   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         summarize();
      end
   end
   // ==========================================================
   // shared tasks
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      regRead <= 1'h1;
      regAddr <= a;
      @(posedge clk_sys);
      regRead <= 1'h0;
      #1 chk("read data", regRdata, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regWrite <= 1'h1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWrite <= 1'h0;
   endtask
   // one-cycle request, state judged after the edge that took it
   task automatic preq(input logic [5:0] r);
      @(posedge clk_sys);
      procReq <= r;
      @(posedge clk_sys);
      procReq <= 6'h00;
      #1;
   endtask
   function automatic logic [3:0] ctrl();
      return {mac_saturate_select, onchip_ram_enable, flash_ctrl_access_enable,
              transfer_ctrl_addr_mode};
   endfunction
   // ==========================================================
   // scenarios
   task automatic testSysControl();
      logic [15:0] v [4] = '{16'hD503, 16'hD401, 16'hF583, 16'hF481};
      rd(OFS_SYSTEM_CONTROL, 16'hD503);
      @(posedge clk_sys);
      flashRegReq <= 1'h1;
      // no on-chip RAM traffic here, so clearing the RAM enable is safe
      for (int i = 0; i < 4; i++) begin
         wr(OFS_SYSTEM_CONTROL, v[i]);
         rd(OFS_SYSTEM_CONTROL, v[i]);
         chk("control outputs", ctrl(), {v[i][13], v[i][8], v[i][7], v[i][1]});
         chk("flash grant", flashRegGrant, v[i][7]);
      end
      wr(8'h04, 16'hFFFF);
      rd(8'h04, 16'h0000);
      rd(OFS_SYSTEM_CONTROL, 16'hF481);
      $display("test system control done");
   endtask
   task automatic testStates();
      chk("state", procStatus.state, PS_EXCEPTION);
      preq(6'h01);
      chk("state", procStatus.state, PS_EXECUTE);
      preq(6'h10);
      chk("bus", {procStatus.state, procStatus.busGrant, procStatus.cpuHalted},
          {PS_BUS_RELEASED, 2'h3});
      @(posedge clk_sys);
      #1 chk("bus", {procStatus.state, procStatus.busGrant}, {PS_EXECUTE, 1'h0});
      for (int i = 0; i < 2; i++) begin
         preq(i == 0 ? 6'h08 : 6'h04);
         chk("stop", {procStatus.state, procStatus.cpuStopped}, {PS_STOPPED, 1'h1});
         preq(6'h02);
         preq(6'h01);
      end
      preq(6'h38);
      chk("exception", {procStatus.state, procStatus.vectorFetch}, {PS_EXCEPTION, 1'h1});
      preq(6'h01);
      @(posedge clk_sys);
      wdtOverflow <= 1'h1;
      @(posedge clk_sys);
      wdtOverflow <= 1'h0;
      #1 chk("wdt", {procStatus.state, procStatus.intMasked}, {PS_RESET, 1'h1});
      chk("control outputs", ctrl(), 4'h5);
      @(posedge clk_sys);
      #1 chk("state", procStatus.state, PS_EXCEPTION);
      rd(OFS_SYSTEM_CONTROL, 16'hD503);
      $display("test processing states done");
   endtask
   task automatic testModes();
      logic [3:0] code;
      logic [15:0] word;
      for (int p = 0; p < 4; p++) begin
         code = (p == 1) ? 4'hD : (p == 2) ? 4'hC : (p == 3) ? 4'h4 : 4'h0;
         word = {4'h5, code, 4'h5, code};
         uBoard.setPins(p[1:0]);
         uBoard.pulseReset();
         rd(OFS_MODE_REPORT, word);
         chk("mode flags", {modeValid, advancedMode, onchipRomEnable, flashProgAllowed,
             modeNumber}, {p != 0, p != 0, p != 0, p == 1 || p == 2, p[1:0]});
         uBoard.setPins(~p[1:0]);
         wr(OFS_MODE_REPORT, 16'hFFFF);
         rd(OFS_MODE_REPORT, word);
         chk("latched mode", modeNumber, p[1:0]);
      end
      $display("test modes done");
   endtask
   // ==========================================================
   // verdict
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      uBoard.pulseReset();
      testSysControl();
      testStates();
      testModes();
      summarize();
   end
endmodule
